// ===== hw/tpop_pkg.sv
// Constants and types shared by the transport packet output port
package tpop_pkg;

   // -------------------------------------------------------------
   // Register offsets
   // -------------------------------------------------------------
   localparam logic [7:0] TPOP_OFS_POL    = 8'h50;  // Output clock polarity control
   localparam logic [7:0] TPOP_OFS_OUTCTL = 8'h5a;  // Output control
   localparam logic [7:0] TPOP_OFS_CFG    = 8'h5b;  // Output configuration
   localparam logic [7:0] TPOP_OFS_STAT   = 8'h5c;  // Status
   localparam logic [7:0] TPOP_OFS_PKTCNT = 8'h5d;  // Packets sent, wraps

   // -------------------------------------------------------------
   // Field positions and reset values
   // -------------------------------------------------------------
   localparam int   TPOP_POL_BIT   = 0;
   localparam int   TPOP_HEM_BIT   = 0;
   localparam int   TPOP_EN_N_BIT  = 0;
   localparam int   TPOP_SER_BIT   = 1;
   localparam int   TPOP_ST_LOCK   = 0;
   localparam int   TPOP_ST_UNDR   = 1;
   localparam int   TPOP_ST_FULL   = 2;
   localparam logic TPOP_POL_RST   = 1'b1;
   localparam logic TPOP_HEM_RST   = 1'b1;
   localparam logic TPOP_EN_N_RST  = 1'b1;
   localparam logic TPOP_SER_RST   = 1'b0;

   // -------------------------------------------------------------
   // Packet layout
   // -------------------------------------------------------------
   localparam int         TPOP_PKT_BYTES = 188;
   localparam logic [7:0] TPOP_TEI_IDX   = 8'h01;  // Header byte holding the error indicator
   localparam int         TPOP_TEI_BIT   = 7;
   localparam logic [2:0] TPOP_LAST_BIT  = 3'h7;   // Last bit of a byte in serial form
   localparam int         TPOP_FIFO_W    = 10;     // Error flag, start flag, byte
   localparam int         TPOP_FIFO_D    = 8;

   // Link side sequencing
   typedef enum logic [0:0] {TPOP_IDLE, TPOP_SEND} tpop_state_t;

endpackage

// ===== hw/tpop_port.sv
// Transport packet output port: dual-clock FIFO and the top module
//
// Overview of operation
// - 188 bytes on 188 consecutive output clocks in parallel form, 1504 in serial form
// - Marking enabled: set header error bit if uncorrectable
// - Marking disabled: header error bit passes unchanged
// - Sync byte position moves at most one clock
// - Output clock runs after lock, from symbol clock
// - Polarity bit lives at 0x50, resets set
// - Polarity set: outputs change on falling edge
// - Data lines held low between packets
// - Start strobe high on first byte only
// - Valid high from first to last byte
// - Block error low throughout an uncorrectable packet
// - Parallel byte or serial bit output form
// - Output clock rate follows symbol clock automatically
`timescale 1ns/1ns

// -------------------------------------------------------------
// Dual-clock FIFO with gray-coded pointers
// -------------------------------------------------------------
module tpop_fifo
   import tpop_pkg::*;
#(
   parameter int W     = TPOP_FIFO_W,
   parameter int DEPTH = TPOP_FIFO_D
) (
   input  wire logic         wr_clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] wr_data,
   input  wire logic         wr_valid,
   output      logic         wr_ready,
   input  wire logic         rd_clk,
   output      logic [W-1:0] rd_data,
   output      logic         rd_valid,
   input  wire logic         rd_ready
);
   localparam int AW = $clog2(DEPTH);

   initial begin
      if (DEPTH < 4 || (1 << AW) != DEPTH) begin
         $error("tpop_fifo depth must be a power of two, at least 4");
      end
   end

   typedef struct packed {
      logic [AW:0] bin;
      logic [AW:0] gray;
      logic [AW:0] s1;
      logic [AW:0] s2;
      logic [AW:0] s3;
      logic [AW:0] q;      // Far pointer once two stages agree
      logic        ready;
   } tpop_ptr_t;

   logic [W-1:0] mem [DEPTH];
   tpop_ptr_t    w_r;
   tpop_ptr_t    w_nxt;
   tpop_ptr_t    r_r;
   tpop_ptr_t    r_nxt;
   logic         push;
   logic         pop;

   // Write side: pointer, read-pointer sync, registered ready
   always_comb begin
      w_nxt    = w_r;
      w_nxt.s1 = r_r.gray;
      w_nxt.s2 = w_r.s1;
      w_nxt.s3 = w_r.s2;
      if (w_r.s2 == w_r.s3) begin
         w_nxt.q = w_r.s3;
      end
      push = wr_valid && w_r.ready;
      if (push) begin
         w_nxt.bin = w_r.bin + 1'b1;
      end
      w_nxt.gray  = w_nxt.bin ^ (w_nxt.bin >> 1);
      w_nxt.ready = (w_nxt.gray != {~w_r.q[AW:AW-1], w_r.q[AW-2:0]});
   end

   always_ff @(posedge wr_clk or posedge rst) begin
      if (rst) begin
         w_r       <= '0;
         w_r.ready <= 1'b1;
      end else begin
         w_r <= w_nxt;
      end
   end

   // Storage written from the write side only
   always_ff @(posedge wr_clk) begin
      if (push) begin
         mem[w_r.bin[AW-1:0]] <= wr_data;
      end
   end

   // Read side: pointer and write-pointer sync
   always_comb begin
      r_nxt    = r_r;
      r_nxt.s1 = w_r.gray;
      r_nxt.s2 = r_r.s1;
      r_nxt.s3 = r_r.s2;
      if (r_r.s2 == r_r.s3) begin
         r_nxt.q = r_r.s3;
      end
      pop = rd_valid && rd_ready;
      if (pop) begin
         r_nxt.bin = r_r.bin + 1'b1;
      end
      r_nxt.gray  = r_nxt.bin ^ (r_nxt.bin >> 1);
      r_nxt.ready = 1'b0;
   end

   always_ff @(posedge rd_clk or posedge rst) begin
      if (rst) begin
         r_r <= '0;
      end else begin
         r_r <= r_nxt;
      end
   end

   assign wr_ready = w_r.ready;
   assign rd_valid = (r_r.gray != r_r.q);
   assign rd_data  = mem[r_r.bin[AW-1:0]];
endmodule

// -------------------------------------------------------------
// Top: register file, header marking, link-side framer
// -------------------------------------------------------------
module tpop_port
   import tpop_pkg::*;
#(
   parameter int PKT_BYTES = TPOP_PKT_BYTES,
   parameter int FIFO_D    = TPOP_FIFO_D
) (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       link_clk,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_write,
   output      logic [7:0] reg_rdata,
   input  wire logic [7:0] in_data,
   input  wire logic       in_sop,
   input  wire logic       in_uncorr,
   input  wire logic       in_valid,
   output      logic       in_ready,
   input  wire logic       sym_lock,
   output      logic [7:0] out_data_bus,
   output      logic       packet_start_strobe,
   output      logic       packet_valid_strobe,
   output      logic       block_error_n,
   output      logic       output_byte_clock
);
   initial begin
      if (PKT_BYTES < 2 || PKT_BYTES > 255) begin
         $error("tpop_port packet length out of range");
      end
   end

   localparam logic [7:0] LAST_IDX = 8'(PKT_BYTES - 1);

   // Core-domain state
   typedef struct packed {
      logic       pol;
      logic       hem;
      logic       en_n;
      logic       ser;
      logic [2:0] lk_s;     // Lock pin synchroniser
      logic       lock;
      logic [7:0] idx;      // Byte index of the packet being accepted
      logic       perr;
      logic [1:0] t1;       // Link event toggles, three stages
      logic [1:0] t2;
      logic [1:0] t3;
      logic [1:0] tq;
      logic [1:0] tp;
      logic       und;
      logic [7:0] pktcnt;
      logic [7:0] rdata;
   } tpop_core_t;

   // Link-domain state; level vector is {ser, en_n, pol, lock}
   typedef struct packed {
      logic [3:0]  s1;
      logic [3:0]  s2;
      logic [3:0]  s3;
      logic [3:0]  q;
      logic        ph;
      tpop_state_t state;
      logic        smode;
      logic [7:0]  cnt;
      logic [2:0]  bitc;
      logic [7:0]  sh;
      logic        perr;
      logic [7:0]  data;
      logic        start;
      logic        valid;
      logic        err_n;
      logic        pkt_tog;
      logic        und_tog;
   } tpop_link_t;

   tpop_core_t                   c_r;
   tpop_core_t                   c_nxt;
   tpop_link_t                   l_r;
   tpop_link_t                   l_nxt;
   logic [TPOP_FIFO_W-1:0]       f_wdata;
   logic [TPOP_FIFO_W-1:0]       f_rdata;
   logic                         f_rvalid;
   logic                         f_pop;
   logic                         f_ready;
   logic                         push;
   logic [7:0]                   mbyte;

   tpop_fifo #(.W(TPOP_FIFO_W), .DEPTH(FIFO_D)) u_fifo (
      .wr_clk   (core_clk),
      .rst      (rst),
      .wr_data  (f_wdata),
      .wr_valid (in_valid),
      .wr_ready (f_ready),
      .rd_clk   (link_clk),
      .rd_data  (f_rdata),
      .rd_valid (f_rvalid),
      .rd_ready (f_pop)
   );

   // -------------------------------------------------------------
   // Core domain
   // -------------------------------------------------------------

   // Registers, header marking, status collection
   always_comb begin
      c_nxt      = c_r;
      c_nxt.lk_s = {c_r.lk_s[1:0], sym_lock};
      if (c_r.lk_s[1] == c_r.lk_s[2]) begin
         c_nxt.lock = c_r.lk_s[2];
      end
      c_nxt.t1 = {l_r.und_tog, l_r.pkt_tog};
      c_nxt.t2 = c_r.t1;
      c_nxt.t3 = c_r.t2;
      c_nxt.tq = (c_r.tq & (c_r.t2 ^ c_r.t3)) | (c_r.t3 & ~(c_r.t2 ^ c_r.t3));
      c_nxt.tp = c_r.tq;

      // Header error bit forced only when marking is on
      mbyte = in_data;
      if (!in_sop && c_r.idx == TPOP_TEI_IDX && c_r.hem && c_r.perr) begin
         mbyte[TPOP_TEI_BIT] = 1'b1;
      end
      f_wdata = {(in_sop ? in_uncorr : c_r.perr), in_sop, mbyte};
      push    = in_valid && f_ready;
      if (push) begin
         if (in_sop) begin
            c_nxt.idx  = TPOP_TEI_IDX;
            c_nxt.perr = in_uncorr;
         end else if (c_r.idx != 8'hff) begin
            c_nxt.idx = c_r.idx + 8'h01;
         end
      end

      // Register writes; clearing underrun loses to a new event
      if (reg_write) begin
         case (reg_addr)
            TPOP_OFS_POL:    c_nxt.pol = reg_wdata[TPOP_POL_BIT];
            TPOP_OFS_OUTCTL: c_nxt.hem = reg_wdata[TPOP_HEM_BIT];
            TPOP_OFS_CFG: begin
               c_nxt.en_n = reg_wdata[TPOP_EN_N_BIT];
               c_nxt.ser  = reg_wdata[TPOP_SER_BIT];
            end
            TPOP_OFS_STAT: begin
               if (reg_wdata[TPOP_ST_UNDR]) begin
                  c_nxt.und = 1'b0;
               end
            end
            default: ;
         endcase
      end
      if (c_r.tq[1] != c_r.tp[1]) begin
         c_nxt.und = 1'b1;
      end
      if (c_r.tq[0] != c_r.tp[0]) begin
         c_nxt.pktcnt = c_r.pktcnt + 8'h01;
      end

      // Registered read data, unmapped reads zero
      c_nxt.rdata = 8'h00;
      case (reg_addr)
         TPOP_OFS_POL:    c_nxt.rdata[TPOP_POL_BIT] = c_r.pol;
         TPOP_OFS_OUTCTL: c_nxt.rdata[TPOP_HEM_BIT] = c_r.hem;
         TPOP_OFS_CFG: begin
            c_nxt.rdata[TPOP_EN_N_BIT] = c_r.en_n;
            c_nxt.rdata[TPOP_SER_BIT]  = c_r.ser;
         end
         TPOP_OFS_STAT: begin
            c_nxt.rdata[TPOP_ST_LOCK] = c_r.lock;
            c_nxt.rdata[TPOP_ST_UNDR] = c_r.und;
            c_nxt.rdata[TPOP_ST_FULL] = ~f_ready;
         end
         TPOP_OFS_PKTCNT: c_nxt.rdata = c_r.pktcnt;
         default:         c_nxt.rdata = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         c_r      <= '0;
         c_r.pol  <= TPOP_POL_RST;
         c_r.hem  <= TPOP_HEM_RST;
         c_r.en_n <= TPOP_EN_N_RST;
         c_r.ser  <= TPOP_SER_RST;
      end else begin
         c_r <= c_nxt;
      end
   end

   // -------------------------------------------------------------
   // Link domain
   // -------------------------------------------------------------

   // Output clock, launch edge and packet sequencing
   always_comb begin
      logic upd;
      logic last_bit;
      logic [7:0] byte_v;
      logic err_v;
      upd      = 1'b0;
      last_bit = 1'b0;
      byte_v   = 8'h00;
      err_v    = 1'b0;
      f_pop    = 1'b0;
      l_nxt    = l_r;
      l_nxt.s1 = {c_r.ser, c_r.en_n, c_r.pol, c_r.lock};
      l_nxt.s2 = l_r.s1;
      l_nxt.s3 = l_r.s2;
      l_nxt.q  = (l_r.q & (l_r.s2 ^ l_r.s3)) | (l_r.s3 & ~(l_r.s2 ^ l_r.s3));

      // Byte clock is half the symbol-derived clock, free running once locked
      if (l_r.q[0]) begin
         l_nxt.ph = ~l_r.ph;
         upd      = (l_r.ph == l_r.q[1]);
      end else begin
         l_nxt.ph = 1'b0;
      end

      // Data, start, valid and error outputs move together on the launch edge only
      if (upd) begin
         case (l_r.state)
            TPOP_IDLE: begin
               l_nxt.data  = 8'h00;
               l_nxt.start = 1'b0;
               l_nxt.valid = 1'b0;
               l_nxt.err_n = 1'b1;
               if (!l_r.q[2] && f_rvalid) begin
                  f_pop = 1'b1;
                  if (f_rdata[8]) begin
                     l_nxt.state = TPOP_SEND;
                     l_nxt.smode = l_r.q[3];
                     l_nxt.sh    = f_rdata[7:0];
                     l_nxt.data  = l_r.q[3] ? {7'h00, f_rdata[7]} : f_rdata[7:0];
                     l_nxt.cnt   = 8'h00;
                     l_nxt.bitc  = 3'h0;
                     l_nxt.perr  = f_rdata[9];
                     l_nxt.start = 1'b1;
                     l_nxt.valid = 1'b1;
                     l_nxt.err_n = ~f_rdata[9];
                  end
               end
            end
            TPOP_SEND: begin
               last_bit    = !l_r.smode || (l_r.bitc == TPOP_LAST_BIT);
               l_nxt.start = 1'b0;
               if (last_bit && l_r.cnt == LAST_IDX) begin
                  l_nxt.state   = TPOP_IDLE;
                  l_nxt.data    = 8'h00;
                  l_nxt.valid   = 1'b0;
                  l_nxt.err_n   = 1'b1;
                  l_nxt.pkt_tog = ~l_r.pkt_tog;
               end else if (last_bit) begin
                  // No gap inside a packet: an underrun sends a zero byte flagged bad
                  if (f_rvalid) begin
                     f_pop  = 1'b1;
                     byte_v = f_rdata[7:0];
                     err_v  = f_rdata[9];
                  end else begin
                     err_v         = 1'b1;
                     l_nxt.und_tog = ~l_r.und_tog;
                  end
                  l_nxt.cnt   = l_r.cnt + 8'h01;
                  l_nxt.bitc  = 3'h0;
                  l_nxt.sh    = byte_v;
                  l_nxt.data  = l_r.smode ? {7'h00, byte_v[7]} : byte_v;
                  l_nxt.perr  = l_r.perr | err_v;
                  l_nxt.valid = 1'b1;
                  l_nxt.err_n = ~(l_r.perr | err_v);
               end else begin
                  // Serial form, most significant bit first
                  l_nxt.bitc = l_r.bitc + 3'h1;
                  l_nxt.sh   = {l_r.sh[6:0], 1'b0};
                  l_nxt.data = {7'h00, l_r.sh[6]};
               end
            end
            default: l_nxt.state = TPOP_IDLE;
         endcase
      end
   end

   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         l_r       <= '0;
         l_r.state <= TPOP_IDLE;
         l_r.err_n <= 1'b1;
      end else begin
         l_r <= l_nxt;
      end
   end

   // Output wiring, all from flip-flops
   assign reg_rdata           = c_r.rdata;
   assign in_ready            = f_ready;
   assign out_data_bus        = l_r.data;
   assign packet_start_strobe = l_r.start;
   assign packet_valid_strobe = l_r.valid;
   assign block_error_n       = l_r.err_n;
   assign output_byte_clock   = l_r.ph;
endmodule

// ===== verif/tpop_port_sva.sv
// Checker for the transport packet output port pins
`timescale 1ns/1ns
module tpop_port_chk
   import tpop_pkg::*;
#(
   parameter int PKT_BYTES = TPOP_PKT_BYTES,
   parameter int FIFO_D    = TPOP_FIFO_D
) (
   input wire logic       core_clk,
   input wire logic       rst,
   input wire logic       link_clk,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_write,
   input wire logic [7:0] reg_rdata,
   input wire logic [7:0] in_data,
   input wire logic       in_sop,
   input wire logic       in_uncorr,
   input wire logic       in_valid,
   input wire logic       in_ready,
   input wire logic       sym_lock,
   input wire logic [7:0] out_data_bus,
   input wire logic       packet_start_strobe,
   input wire logic       packet_valid_strobe,
   input wire logic       block_error_n,
   input wire logic       output_byte_clock
);
   // --------
   // Link cycles spent inside the current packet
   // --------
   logic [15:0] run_r;
   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         run_r <= 16'h0000;
      end else begin
         run_r <= packet_valid_strobe ? run_r + 16'h0001 : 16'h0000;
      end
   end

   // Polarity the host last wrote, for the launch edge check
   logic pol_seen_r;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pol_seen_r <= TPOP_POL_RST;
      end else if (reg_write && reg_addr == TPOP_OFS_POL) begin
         pol_seen_r <= reg_wdata[TPOP_POL_BIT];
      end
   end

   // Named sequences: lock held eight cycles, start strobe for one byte
   sequence s_locked;
      sym_lock [*8];
   endsequence
   sequence s_start_byte;
      packet_start_strobe ##1 !packet_start_strobe;
   endsequence

   chk_run_length: assert property (@(posedge link_clk) disable iff (rst)
      run_r != 16'h0000 && !packet_valid_strobe |-> run_r == 16'(2 * PKT_BYTES) || run_r == 16'(16 * PKT_BYTES))
      else $error("packet length wrong");
   chk_idle_data_low: assert property (@(posedge link_clk) disable iff (rst)
      !packet_valid_strobe |-> out_data_bus == 8'h00) else $error("idle data not low");
   chk_start_one_byte: assert property (@(posedge link_clk) disable iff (rst)
      $rose(packet_start_strobe) |=> s_start_byte) else $error("start strobe length wrong");
   chk_valid_with_start: assert property (@(posedge link_clk) disable iff (rst)
      $rose(packet_valid_strobe) |-> packet_start_strobe) else $error("valid rose without start");
   chk_gap_after_packet: assert property (@(posedge link_clk) disable iff (rst)
      $fell(packet_valid_strobe) |-> !packet_valid_strobe [*2]) else $error("no idle byte after packet");
   chk_error_holds: assert property (@(posedge link_clk) disable iff (rst)
      packet_valid_strobe && !block_error_n |=> !block_error_n || !packet_valid_strobe)
      else $error("block error released early");
   chk_error_idle_high: assert property (@(posedge link_clk) disable iff (rst)
      !packet_valid_strobe |-> block_error_n) else $error("block error low when idle");
   chk_launch_edge: assert property (@(posedge link_clk) disable iff (rst)
      $changed(packet_valid_strobe) || $changed(out_data_bus) || $changed(packet_start_strobe)
      |-> $changed(output_byte_clock) && output_byte_clock != pol_seen_r) else $error("output moved off launch edge");
   chk_clock_runs: assert property (@(posedge link_clk) disable iff (rst)
      s_locked |-> output_byte_clock != $past(output_byte_clock)) else $error("byte clock stalled");
   chk_pol_readback: assert property (@(posedge core_clk) disable iff (rst)
      reg_write && reg_addr == TPOP_OFS_POL ##1 (reg_addr == TPOP_OFS_POL) [*2]
      |-> reg_rdata[0] == $past(reg_wdata[0], 2)) else $error("polarity readback wrong");
endmodule

bind tpop_port tpop_port_chk #(.PKT_BYTES(PKT_BYTES), .FIFO_D(FIFO_D)) u_chk (
   .core_clk(core_clk), .rst(rst), .link_clk(link_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_write(reg_write), .reg_rdata(reg_rdata), .in_data(in_data), .in_sop(in_sop), .in_uncorr(in_uncorr),
   .in_valid(in_valid), .in_ready(in_ready), .sym_lock(sym_lock), .out_data_bus(out_data_bus),
   .packet_start_strobe(packet_start_strobe), .packet_valid_strobe(packet_valid_strobe),
   .block_error_n(block_error_n), .output_byte_clock(output_byte_clock));

// ===== verif/tpop_sink.sv
// Downstream transport receiver model for the output port
`timescale 1ns/1ns
module tpop_sink (
   input  wire logic       obc,
   input  wire logic [7:0] data,
   input  wire logic       sop,
   input  wire logic       vld,
   input  wire logic       err_n,
   input  wire logic       pol,
   input  wire logic       ser,
   output      logic [7:0] pkts,
   output      logic [7:0] len,
   output      logic [7:0] b0,
   output      logic [7:0] b1,
   output      logic [7:0] starts,
   output      logic       bad,
   output      logic       idle_nz
);
   logic [7:0] sh;
   logic [3:0] nbit;
   logic       busy;

   // Packet counter, busy flag and idle-data flag start clear
   initial begin
      pkts = 8'h00;
      busy = 1'b0;
      idle_nz = 1'b0;
   end

   // --------
   // Sample at the edge opposite the launch edge
   // --------
   always @(obc) begin
      if (obc == pol) begin
         if (vld && !busy) begin
            busy = 1'b1;
            len = 8'h00;
            starts = 8'h00;
            bad = 1'b0;
            nbit = 4'h0;
         end
         if (vld) begin
            sh = ser ? {sh[6:0], data[0]} : data;
            nbit = ser ? nbit + 4'h1 : 4'h8;
            starts = starts + {7'h0, sop};
            bad = bad | ~err_n;
            if (nbit == 4'h8) begin
               b0 = (len == 8'h00) ? sh : b0;
               b1 = (len == 8'h01) ? sh : b1;
               len = len + 8'h01;
               nbit = 4'h0;
            end
         end else begin
            pkts = pkts + {7'h0, busy};
            busy = 1'b0;
            idle_nz = idle_nz | (data != 8'h00);
         end
      end
   end
endmodule

// ===== verif/tpop_port_test.sv
// Self-checking bench for the transport packet output port
`timescale 1ns/1ns
module tpop_port_test
   import tpop_pkg::*;
;
   localparam int PKT = 12;
   logic       core_clk  = 1'b0;
   logic       link_clk  = 1'b0;
   logic       rst       = 1'b1;
   logic       reg_write = 1'b0;
   logic       in_sop    = 1'b0;
   logic       in_uncorr = 1'b0;
   logic       in_valid  = 1'b0;
   logic       sym_lock  = 1'b1;
   logic       pol_m     = 1'b1;
   logic       ser_m     = 1'b0;
   logic [7:0] reg_addr  = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] in_data   = 8'h00;
   logic [7:0] reg_rdata, out_data_bus, pkts, len, b0, b1, starts;
   logic       in_ready, packet_start_strobe, packet_valid_strobe, block_error_n;
   logic       output_byte_clock, bad, idle_nz, c;
   int         errors = 0;
   int         total_checks = 0;
   int         np = 0;

   tpop_port #(.PKT_BYTES(PKT), .FIFO_D(TPOP_FIFO_D)) dut (
      .core_clk(core_clk), .rst(rst), .link_clk(link_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_rdata(reg_rdata), .in_data(in_data), .in_sop(in_sop), .in_uncorr(in_uncorr),
      .in_valid(in_valid), .in_ready(in_ready), .sym_lock(sym_lock), .out_data_bus(out_data_bus),
      .packet_start_strobe(packet_start_strobe), .packet_valid_strobe(packet_valid_strobe),
      .block_error_n(block_error_n), .output_byte_clock(output_byte_clock));
   tpop_sink u_sink (
      .obc(output_byte_clock), .data(out_data_bus), .sop(packet_start_strobe), .vld(packet_valid_strobe),
      .err_n(block_error_n), .pol(pol_m), .ser(ser_m), .pkts(pkts), .len(len), .b0(b0), .b1(b1),
      .starts(starts), .bad(bad), .idle_nz(idle_nz));

   // Core clock and phase-shifted link clock
   initial begin
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      #3 link_clk = 1'b1;
      forever #80 link_clk = ~link_clk;
   end

   // --------
   // Compare, verdict and bus tasks
   // --------
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge core_clk);
      reg_write <= 1'b0;
      repeat (100) @(posedge core_clk);  // Let config cross to link side
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      chk("register", reg_rdata, e);
   endtask
   // Feed one packet, optionally pausing the source before byte stall
   task automatic send(input logic u, input logic [7:0] h, input int stall);
      int n;
      @(posedge core_clk);
      for (int k = 0; k < PKT; k++) begin
         if (k == stall) begin
            in_valid <= 1'b0;
            repeat (400) @(posedge core_clk);
         end
         in_valid  <= 1'b1;
         in_sop    <= (k == 0);
         in_uncorr <= u;
         in_data   <= (k == 0) ? 8'h47 : (k == 1) ? h : 8'(k);
         n = 0;
         do begin
            @(negedge core_clk);
            n++;
         end while (!in_ready && n < 20000);
         @(posedge core_clk);
      end
      in_valid <= 1'b0;
   endtask
   task automatic pkt_ok(input string t, input logic [7:0] h, input logic e);
      int n;
      np++;
      n = 0;
      while (pkts !== 8'(np) && n < 20000) begin
         @(posedge core_clk);
         n++;
      end
      chk("packets", pkts, 8'(np));
      chk("length", len, 8'(PKT));
      chk("sync byte", b0, 8'h47);
      chk("header", b1, h);
      chk("start", starts, 8'h01);
      chk("error", {7'h0, bad}, {7'h0, e});
      chk("idle data", {7'h0, idle_nz}, 8'h00);
      $display("test %s done", t);
   endtask

   // Main sequence
   initial begin
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      rd(TPOP_OFS_POL, 8'h01);
      rd(TPOP_OFS_OUTCTL, 8'h01);
      rd(8'h3f, 8'h00);
      $display("test reset values done");
      fork
         send(1'b0, 8'h1f, PKT);
         begin
            repeat (300) @(posedge core_clk);
            @(negedge core_clk);
            chk("fifo ready", {7'h0, in_ready}, 8'h00);
            chk("held packets", pkts, 8'h00);
            wr(TPOP_OFS_CFG, 8'h00);
         end
      join
      pkt_ok("enable", 8'h1f, 1'b0);
      for (int i = 0; i < 4; i++) begin
         wr(TPOP_OFS_OUTCTL, 8'(i >> 1));
         send(1'b1, i[0] ? 8'h9f : 8'h1f, PKT);
         pkt_ok("marking", (i != 0) ? 8'h9f : 8'h1f, 1'b1);
      end
      send(1'b0, 8'h1f, PKT);
      send(1'b0, 8'h1f, PKT);
      np++;
      pkt_ok("back to back", 8'h1f, 1'b0);
      send(1'b0, 8'h1f, 4);
      pkt_ok("underrun", 8'h1f, 1'b1);
      wr(TPOP_OFS_POL, 8'h00);
      rd(TPOP_OFS_POL, 8'h00);
      pol_m = 1'b0;
      send(1'b0, 8'h1f, PKT);
      pkt_ok("rising launch", 8'h1f, 1'b0);
      rd(TPOP_OFS_STAT, 8'h03);
      wr(TPOP_OFS_STAT, 8'h02);
      rd(TPOP_OFS_STAT, 8'h01);
      rd(TPOP_OFS_PKTCNT, 8'h09);
      wr(TPOP_OFS_POL, 8'h01);
      pol_m = 1'b1;
      wr(TPOP_OFS_CFG, 8'h02);
      ser_m = 1'b1;
      send(1'b0, 8'h1f, PKT);
      pkt_ok("serial", 8'h1f, 1'b0);
      wr(TPOP_OFS_CFG, 8'h00);
      ser_m = 1'b0;
      @(posedge core_clk);
      sym_lock <= 1'b0;
      repeat (20) @(negedge link_clk);
      chk("clock stopped", {7'h0, output_byte_clock}, 8'h00);
      @(posedge core_clk);
      sym_lock <= 1'b1;
      repeat (20) @(negedge link_clk);
      c = output_byte_clock;
      @(negedge link_clk);
      chk("clock runs", {7'h0, output_byte_clock}, {7'h0, ~c});
      $display("test lock done");
      final_report();
   end

   // Watchdog against a hang
   initial begin
      #900000;
      errors++;
      $display("watchdog expired");
      final_report();
   end
endmodule
